/* hw/sam_top.sv */
`timescale 1ns/100ps
// What this block does
// - Bad first input assignment raises 211.
// - Bad second assignment group raises 212.
// - Stored parameter checksum failure raises 240.
// - Either over-travel input raises 260.
// - Forced-alarm input raises 570.
// - Bad motor code raises 5F0 until fixed.
// - Link alarms clearable, never logged in history.
// - Writing 1 to 4000h clears alarm.
// - Control word bit 7 leaves fault after clear.
// - Alarm clear input clears a clearable alarm.
// - Link alarm cleared once status code zero.
module sam_top (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Asynchronous pins.
	input wire logic pos_limit_i,
	input wire logic neg_limit_i,
	input wire logic forced_alarm_i,
	input wire logic alarm_clear_input_i,
	// Parameter values from the same clock domain.
	input wire logic [3:0] input_function_select_0_i,
	input wire logic [3:0] input_function_select_1_i,
	input wire logic [3:0] input_function_select_2_i,
	input wire logic [3:0] input_function_select_3_i,
	input wire logic [3:0] input_function_select_4_i,
	input wire logic [3:0] second_function_select_0_i,
	input wire logic [3:0] second_function_select_1_i,
	input wire logic [3:0] second_function_select_2_i,
	input wire logic [3:0] second_function_select_3_i,
	input wire logic [15:0] motor_code_param_i,
	input wire logic store_crc_fail_i,
	input wire logic panel_alarm_clear_function_i,
	// Fieldbus object writes.
	input wire logic obj_wr_i,
	input wire logic [15:0] obj_index_i,
	input wire logic [15:0] obj_data_i,
	// Slave controller register port.
	input wire logic link_wr_i,
	input wire logic link_rd_i,
	input wire logic [15:0] link_addr_i,
	input wire logic [15:0] link_wdata_i,
	output logic [15:0] link_rdata_o,
	// Link error report from the slave controller core.
	input wire logic link_err_i,
	input wire logic [15:0] link_err_code_i,
	// History read.
	input wire logic [1:0] hist_sel_i,
	output logic [11:0] hist_code_o,
	// Status.
	output logic [11:0] alarm_code_o,
	output logic alarm_active_o,
	output logic link_alarm_o,
	output logic [1:0] drive_state_o
);
	sam_sel_if #(.N(sam_pkg::SEL_N1)) first_if ();
	sam_sel_if #(.N(sam_pkg::SEL_N2)) second_if ();
	logic [sam_pkg::PIN_N-1:0] pin_raw;
	logic [sam_pkg::PIN_N-1:0] sync1;
	logic [sam_pkg::PIN_N-1:0] sync2;
	logic [sam_pkg::PIN_N-1:0] sync3;
	logic [sam_pkg::PIN_N-1:0] pin_lvl;
	logic clear_pin_d;
	logic [15:0] link_control;
	logic [15:0] link_status;
	logic cw_bit_d;
	logic [11:0] hist_mem [sam_pkg::HIST_N];
	logic [sam_pkg::HIST_AW-1:0] hist_wp;
	logic [11:0] next_cause;
	logic motor_bad;
	logic clear_req;
	logic cw_rise;
	logic latch_now;

	assign first_if.sel[0] = input_function_select_0_i;
	assign first_if.sel[1] = input_function_select_1_i;
	assign first_if.sel[2] = input_function_select_2_i;
	assign first_if.sel[3] = input_function_select_3_i;
	assign first_if.sel[4] = input_function_select_4_i;
	assign second_if.sel[0] = second_function_select_0_i;
	assign second_if.sel[1] = second_function_select_1_i;
	assign second_if.sel[2] = second_function_select_2_i;
	assign second_if.sel[3] = second_function_select_3_i;

	// Duplicate or missing assignment checks for both groups.
	sam_alloc_check #(.N(sam_pkg::SEL_N1)) u_first_check (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.sel_if(first_if.checker_side)
	);
	sam_alloc_check #(.N(sam_pkg::SEL_N2)) u_second_check (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.sel_if(second_if.checker_side)
	);

	assign pin_raw[sam_pkg::PIN_POS_LIMIT] = pos_limit_i;
	assign pin_raw[sam_pkg::PIN_NEG_LIMIT] = neg_limit_i;
	assign pin_raw[sam_pkg::PIN_FORCED] = forced_alarm_i;
	assign pin_raw[sam_pkg::PIN_CLEAR] = alarm_clear_input_i;

	// Three-stage synchronisers; a level is taken once stages two and
	// three agree, which also rejects a single-cycle glitch.
	genvar g;
	generate
		for (g = 0; g < sam_pkg::PIN_N; g++) begin : g_sync
			always_ff @(posedge mclk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					sync1[g] <= 1'b0;
					sync2[g] <= 1'b0;
					sync3[g] <= 1'b0;
					pin_lvl[g] <= 1'b0;
				end else begin
					sync1[g] <= pin_raw[g];
					sync2[g] <= sync1[g];
					sync3[g] <= sync2[g];
					if (sync2[g] == sync3[g]) begin
						pin_lvl[g] <= sync3[g];
					end
				end
			end
		end
	endgenerate

	// A motor code is valid when it names one of the known motors.
	assign motor_bad = (motor_code_param_i == 16'h0000) ||
		(motor_code_param_i > sam_pkg::MOTOR_CODE_MAX);

	// Active cause, highest priority first. Clears do not remove a cause,
	// so a lingering condition simply latches again after a clear.
	always_comb begin
		next_cause = sam_pkg::ALM_NONE;
		if (motor_bad) begin
			next_cause = sam_pkg::ALM_MOTOR_CODE;
		end else if (store_crc_fail_i) begin
			next_cause = sam_pkg::ALM_STORE_CRC;
		end else if (first_if.bad) begin
			next_cause = sam_pkg::ALM_IN_ALLOC;
		end else if (second_if.bad) begin
			next_cause = sam_pkg::ALM_IN_SECOND;
		end else if (pin_lvl[sam_pkg::PIN_POS_LIMIT] ||
				pin_lvl[sam_pkg::PIN_NEG_LIMIT]) begin
			next_cause = sam_pkg::ALM_OVERTRAVEL;
		end else if (pin_lvl[sam_pkg::PIN_FORCED]) begin
			next_cause = sam_pkg::ALM_FORCED;
		end
	end

	// The three clear routes: object write, panel function, clear pin edge.
	assign clear_req = (obj_wr_i && obj_index_i == sam_pkg::OBJ_ALARM_CLEAR &&
		obj_data_i == sam_pkg::ALARM_CLEAR_VALUE) ||
		panel_alarm_clear_function_i ||
		(pin_lvl[sam_pkg::PIN_CLEAR] && !clear_pin_d);

	// Fault reset is the rising edge of control word bit 7.
	assign cw_rise = obj_wr_i && obj_index_i == sam_pkg::OBJ_CONTROL_WORD &&
		obj_data_i[sam_pkg::CW_FAULT_RESET_BIT] && !cw_bit_d;

	assign latch_now = !alarm_active_o && next_cause != sam_pkg::ALM_NONE;

	// Edge memories for the clear pin and the control word bit.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			clear_pin_d <= 1'b0;
			cw_bit_d <= 1'b0;
		end else begin
			clear_pin_d <= pin_lvl[sam_pkg::PIN_CLEAR];
			if (obj_wr_i && obj_index_i == sam_pkg::OBJ_CONTROL_WORD) begin
				cw_bit_d <= obj_data_i[sam_pkg::CW_FAULT_RESET_BIT];
			end
		end
	end

	// Alarm latch: first cause wins and is held until a clear.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			alarm_code_o <= sam_pkg::ALM_NONE;
			alarm_active_o <= 1'b0;
		end else if (latch_now) begin
			alarm_code_o <= next_cause;
			alarm_active_o <= 1'b1;
		end else if (clear_req) begin
			alarm_code_o <= sam_pkg::ALM_NONE;
			alarm_active_o <= 1'b0;
		end
	end

	// History of drive alarms; link alarms take another path and are
	// never written here.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hist_wp <= '0;
			for (int i = 0; i < sam_pkg::HIST_N; i++) begin
				hist_mem[i] <= sam_pkg::ALM_NONE;
			end
		end else if (latch_now) begin
			hist_mem[hist_wp] <= next_cause;
			hist_wp <= hist_wp + 2'h1;
		end
	end

	// History read, one cycle after the select.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hist_code_o <= sam_pkg::ALM_NONE;
		end else begin
			hist_code_o <= hist_mem[hist_sel_i];
		end
	end

	// Control register; only the acknowledge bit has an effect here.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			link_control <= sam_pkg::LINK_CONTROL_RESET;
		end else if (link_wr_i && link_addr_i == sam_pkg::REG_LINK_CONTROL) begin
			link_control <= link_wdata_i;
		end
	end

	// Status code: a new error beats an acknowledge in the same cycle.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			link_status <= 16'h0000;
		end else if (link_err_i) begin
			link_status <= link_err_code_i;
		end else if (link_wr_i && link_addr_i == sam_pkg::REG_LINK_CONTROL &&
				link_wdata_i[sam_pkg::LINK_ERR_ACK_BIT]) begin
			link_status <= 16'h0000;
		end
	end

	// Register read port, one cycle latency, unmapped reads give zero.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			link_rdata_o <= 16'h0000;
		end else if (link_rd_i) begin
			case (link_addr_i)
				sam_pkg::REG_LINK_CONTROL: link_rdata_o <= link_control;
				sam_pkg::REG_LINK_STATUS: link_rdata_o <= link_status;
				default: link_rdata_o <= 16'h0000;
			endcase
		end
	end

	// Link alarm rises with a link error and falls one cycle after the status code returns to zero.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			link_alarm_o <= 1'b0;
		end else begin
			link_alarm_o <= link_err_i || link_status != 16'h0000;
		end
	end

	// Drive state machine. Fault reset needs both alarms already clear.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			drive_state_o <= sam_pkg::SAM_ST_SOD;
		end else begin
			case (drive_state_o)
				sam_pkg::SAM_ST_SOD: begin
					if (latch_now || link_err_i) begin
						drive_state_o <= sam_pkg::SAM_ST_FAULT;
					end
				end
				sam_pkg::SAM_ST_FAULT: begin
					if (!alarm_active_o && !link_alarm_o && !latch_now) begin
						drive_state_o <= sam_pkg::SAM_ST_CLEARED;
					end
				end
				sam_pkg::SAM_ST_CLEARED: begin
					if (latch_now || link_err_i || link_alarm_o) begin
						drive_state_o <= sam_pkg::SAM_ST_FAULT;
					end else if (cw_rise) begin
						drive_state_o <= sam_pkg::SAM_ST_SOD;
					end
				end
				default: drive_state_o <= sam_pkg::SAM_ST_FAULT;
			endcase
		end
	end
endmodule

/* hw/sam_pkg.sv */
package sam_pkg;
	// Alarm codes, main code in the upper byte, extra code in the low nibble.
	localparam logic [11:0] ALM_NONE = 12'h000;
	localparam logic [11:0] ALM_IN_ALLOC = 12'h211;
	localparam logic [11:0] ALM_IN_SECOND = 12'h212;
	localparam logic [11:0] ALM_STORE_CRC = 12'h240;
	localparam logic [11:0] ALM_OVERTRAVEL = 12'h260;
	localparam logic [11:0] ALM_FORCED = 12'h570;
	localparam logic [11:0] ALM_MOTOR_CODE = 12'h5f0;

	// Fieldbus objects and fields.
	localparam logic [15:0] OBJ_ALARM_CLEAR = 16'h4000;
	localparam logic [15:0] OBJ_CONTROL_WORD = 16'h6040;
	localparam logic [15:0] ALARM_CLEAR_VALUE = 16'h0001;
	localparam int CW_FAULT_RESET_BIT = 7;

	// Slave controller registers.
	localparam logic [15:0] REG_LINK_CONTROL = 16'h0120;
	localparam logic [15:0] REG_LINK_STATUS = 16'h0134;
	localparam int LINK_ERR_ACK_BIT = 4;
	localparam logic [15:0] LINK_CONTROL_RESET = 16'h0000;

	// Function assignment parameters.
	localparam int SEL_W = 4;
	localparam int SEL_N1 = 5;
	localparam int SEL_N2 = 4;

	// Motor code parameter: codes 1 to this limit name a known motor.
	localparam int MOTOR_W = 16;
	localparam logic [15:0] MOTOR_CODE_MAX = 16'h0040;

	// History depth.
	localparam int HIST_N = 4;
	localparam int HIST_AW = 2;

	// Input pins, index into the synchronised pin vector.
	localparam int PIN_N = 4;
	localparam int PIN_POS_LIMIT = 0;
	localparam int PIN_NEG_LIMIT = 1;
	localparam int PIN_FORCED = 2;
	localparam int PIN_CLEAR = 3;

	// Drive state machine, Gray steps except the two-bit return from cleared to SOD.
	typedef enum logic [1:0] {
		SAM_ST_SOD = 2'b00,
		SAM_ST_FAULT = 2'b01,
		SAM_ST_CLEARED = 2'b11
	} sam_state_e;
endpackage

/* hw/sam_sel_if.sv */
`timescale 1ns/100ps
interface sam_sel_if #(parameter int N = 4);
	logic [sam_pkg::SEL_W-1:0] sel [N];
	logic bad;

	// The top drives the selections, the checker answers.
	modport owner (output sel, input bad);
	modport checker_side (input sel, output bad);
endinterface

/* hw/sam_alloc_check.sv */
`timescale 1ns/100ps
module sam_alloc_check #(
	parameter int N = 4
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Selections in, verdict out.
	sam_sel_if.checker_side sel_if
);
	logic next_bad;

	// Unassigned slot or two slots on one function both count as bad.
	always_comb begin
		next_bad = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (sel_if.sel[i] == '0) begin
				next_bad = 1'b1;
			end
			for (int j = i + 1; j < N; j++) begin
				if (sel_if.sel[i] == sel_if.sel[j]) begin
					next_bad = 1'b1;
				end
			end
		end
	end

	// Registered so the long compare chain does not reach the latch.
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sel_if.bad <= 1'b0;
		end else begin
			sel_if.bad <= next_bad;
		end
	end
endmodule

/* dv/sam_top_sva.sv */
`timescale 1ns/100ps
module sam_checker (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Requests and causes.
	input wire logic obj_wr_i,
	input wire logic [15:0] obj_index_i,
	input wire logic [15:0] obj_data_i,
	input wire logic link_rd_i,
	input wire logic [15:0] link_addr_i,
	input wire logic link_err_i,
	input wire logic [15:0] link_err_code_i,
	input wire logic [15:0] motor_code_param_i,
	input wire logic store_crc_fail_i,
	// Status.
	input wire logic [15:0] link_rdata_o,
	input wire logic [11:0] alarm_code_o,
	input wire logic alarm_active_o,
	input wire logic link_alarm_o,
	input wire logic [1:0] drive_state_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	// A motor code outside one to the limit names no motor.
	wire logic bad_motor = motor_code_param_i == 16'h0000
		|| motor_code_param_i > sam_pkg::MOTOR_CODE_MAX;
	wire logic obj_clr = obj_wr_i && obj_index_i == sam_pkg::OBJ_ALARM_CLEAR
		&& obj_data_i == sam_pkg::ALARM_CLEAR_VALUE;
	motor_alarm_a: assert property (
		bad_motor && !alarm_active_o |-> ##[1:3] (alarm_active_o
		&& alarm_code_o == sam_pkg::ALM_MOTOR_CODE))
		else $error("motor alarm missing");
	crc_alarm_a: assert property (
		store_crc_fail_i && !bad_motor && !alarm_active_o |-> ##[1:3]
		(alarm_active_o && alarm_code_o == sam_pkg::ALM_STORE_CRC))
		else $error("checksum alarm missing");
	code_hold_a: assert property (
		alarm_active_o && $past(alarm_active_o) |-> $stable(alarm_code_o))
		else $error("alarm code changed");
	fault_held_a: assert property (
		alarm_active_o && $past(alarm_active_o)
		|-> drive_state_o == sam_pkg::SAM_ST_FAULT)
		else $error("alarm without fault state");
	obj_clear_a: assert property (
		obj_clr && alarm_active_o |=> !alarm_active_o)
		else $error("object clear ignored");
	fault_exit_a: assert property (
		drive_state_o == sam_pkg::SAM_ST_FAULT
		|=> drive_state_o != sam_pkg::SAM_ST_SOD)
		else $error("fault left without clear");
	link_raise_a: assert property (
		link_err_i && link_err_code_i != 16'h0000 |=> link_alarm_o [*2])
		else $error("link alarm missing");
	link_zero_a: assert property (
		link_rd_i && link_addr_i == sam_pkg::REG_LINK_STATUS
		&& !link_alarm_o && !link_err_i |=> link_rdata_o == 16'h0000)
		else $error("status not zero");
	clear_seen_c: cover property ($fell(alarm_active_o));
	link_seen_c: cover property ($fell(link_alarm_o));
	reset_seen_c: cover property (drive_state_o == sam_pkg::SAM_ST_CLEARED
		##1 drive_state_o == sam_pkg::SAM_ST_SOD);
endmodule

bind sam_top sam_checker i_chk (.mclk_i(mclk_i), .resetn_i(resetn_i),
	.obj_wr_i(obj_wr_i), .obj_index_i(obj_index_i),
	.obj_data_i(obj_data_i), .link_rd_i(link_rd_i),
	.link_addr_i(link_addr_i), .link_err_i(link_err_i),
	.link_err_code_i(link_err_code_i),
	.motor_code_param_i(motor_code_param_i),
	.store_crc_fail_i(store_crc_fail_i), .link_rdata_o(link_rdata_o),
	.alarm_code_o(alarm_code_o), .alarm_active_o(alarm_active_o),
	.link_alarm_o(link_alarm_o), .drive_state_o(drive_state_o));

/* dv/sam_master.sv */
`timescale 1ns/100ps
module sam_master (
	// Clock and read data.
	input wire logic mclk_i,
	input wire logic [15:0] link_rdata_i,
	// Object writes and register port.
	output logic obj_wr_o,
	output logic [15:0] obj_index_o,
	output logic [15:0] obj_data_o,
	output logic link_wr_o,
	output logic link_rd_o,
	output logic [15:0] link_addr_o,
	output logic [15:0] link_wdata_o
);
	// Idle bus; released fields are scrambled so stale data never helps.
	initial begin
		{obj_wr_o, link_wr_o, link_rd_o} = 3'b000;
		{obj_index_o, obj_data_o} = 32'h00000000;
		{link_addr_o, link_wdata_o} = 32'h00000000;
	end
	task automatic obj(input logic [15:0] idx, input logic [15:0] dat);
		@(posedge mclk_i);
		obj_wr_o <= 1'b1;
		obj_index_o <= idx;
		obj_data_o <= dat;
		@(posedge mclk_i);
		obj_wr_o <= 1'b0;
		obj_index_o <= ~idx;
		obj_data_o <= ~dat;
	endtask
	// One register access; returns once the read data has settled.
	task automatic acc(input logic wr, input logic [15:0] a,
		input logic [15:0] d);
		@(posedge mclk_i);
		link_wr_o <= wr;
		link_rd_o <= !wr;
		link_addr_o <= a;
		link_wdata_o <= d;
		@(posedge mclk_i);
		{link_wr_o, link_rd_o} <= 2'b00;
		link_addr_o <= ~a;
		link_wdata_o <= ~d;
		@(posedge mclk_i);
	endtask
	task automatic clear_alarm();
		obj(sam_pkg::OBJ_ALARM_CLEAR, sam_pkg::ALARM_CLEAR_VALUE);
	endtask
	// Bit seven must rise, so it is written low first.
	task automatic fault_reset();
		obj(sam_pkg::OBJ_CONTROL_WORD, 16'h0000);
		obj(sam_pkg::OBJ_CONTROL_WORD, 16'h0080);
	endtask
	// Polling is bounded so a stuck status cannot hang the master.
	task automatic link_clear();
		int n;
		acc(1'b1, sam_pkg::REG_LINK_CONTROL, 16'h0010);
		n = 0;
		do begin
			acc(1'b0, sam_pkg::REG_LINK_STATUS, 16'h0000);
			n++;
		end while (link_rdata_i !== 16'h0000 && n < 8);
		fault_reset();
	endtask
endmodule

/* dv/test_servo_alarm_manager.sv */
`timescale 1ns/100ps
`define CMP(o, e) \
	n_tests++; \
	if ((o) !== (e)) begin \
		n_mismatch++; \
		$display("FAIL %0t got %h want %h", $time, o, e); \
	end
module test_servo_alarm_manager;
	logic mclk_i = 1'b0, resetn_i = 1'b0, pos_limit_i = 1'b0;
	logic neg_limit_i = 1'b0, forced_alarm_i = 1'b0, link_err_i = 1'b0;
	logic alarm_clear_input_i = 1'b0, store_crc_fail_i = 1'b0;
	logic panel_alarm_clear_function_i = 1'b0, look = 1'b0, seen = 1'b0;
	logic [15:0] motor_code_param_i = 16'h0010, link_err_code_i = 16'h0000;
	logic [15:0] obj_index_i, obj_data_i, link_addr_i, link_wdata_i;
	logic [15:0] link_rdata_o, lcode;
	logic obj_wr_i, link_wr_i, link_rd_i, alarm_active_o, link_alarm_o;
	logic [3:0] sel1 [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
	logic [3:0] sel2 [4] = '{4'h1, 4'h2, 4'h3, 4'h4};
	logic [1:0] hist_sel_i = 2'b00, drive_state_o;
	logic [11:0] hist_code_o, alarm_code_o;
	logic [17:0] expq [$];
	logic [11:0] codes [6] = '{sam_pkg::ALM_IN_ALLOC, sam_pkg::ALM_IN_SECOND,
		sam_pkg::ALM_STORE_CRC, sam_pkg::ALM_OVERTRAVEL,
		sam_pkg::ALM_OVERTRAVEL, sam_pkg::ALM_FORCED};
	int n_tests = 0, n_mismatch = 0, cyc = 0;
	integer seed = 32'h84669be1;
	always #2 mclk_i = ~mclk_i;
	sam_top i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.pos_limit_i(pos_limit_i), .neg_limit_i(neg_limit_i),
		.forced_alarm_i(forced_alarm_i),
		.alarm_clear_input_i(alarm_clear_input_i),
		.motor_code_param_i(motor_code_param_i),
		.store_crc_fail_i(store_crc_fail_i),
		.panel_alarm_clear_function_i(panel_alarm_clear_function_i),
		.obj_wr_i(obj_wr_i), .obj_index_i(obj_index_i),
		.obj_data_i(obj_data_i), .link_wr_i(link_wr_i),
		.link_rd_i(link_rd_i), .link_addr_i(link_addr_i),
		.link_wdata_i(link_wdata_i), .link_rdata_o(link_rdata_o),
		.link_err_i(link_err_i), .link_err_code_i(link_err_code_i),
		.hist_sel_i(hist_sel_i), .hist_code_o(hist_code_o),
		.alarm_code_o(alarm_code_o), .alarm_active_o(alarm_active_o),
		.link_alarm_o(link_alarm_o), .drive_state_o(drive_state_o),
		.input_function_select_0_i(sel1[0]),
		.input_function_select_1_i(sel1[1]), .input_function_select_2_i(sel1[2]),
		.input_function_select_3_i(sel1[3]), .input_function_select_4_i(sel1[4]),
		.second_function_select_0_i(sel2[0]),
		.second_function_select_1_i(sel2[1]),
		.second_function_select_2_i(sel2[2]),
		.second_function_select_3_i(sel2[3]));
	sam_master i_mst (.mclk_i(mclk_i), .link_rdata_i(link_rdata_o),
		.obj_wr_o(obj_wr_i), .obj_index_o(obj_index_i),
		.obj_data_o(obj_data_i), .link_wr_o(link_wr_i), .link_rd_o(link_rd_i),
		.link_addr_o(link_addr_i), .link_wdata_o(link_wdata_i));
	task automatic wt(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	// A note is judged one edge later, against the output its kind names.
	task automatic chk(input logic [1:0] k, input logic [15:0] v);
		expq.push_back({k, v});
		look <= ~look;
		wt(1);
	endtask
	always @(posedge mclk_i) begin
		logic [17:0] e;
		logic [15:0] o;
		if (look !== seen) begin
			seen = look;
			e = expq.pop_front();
			case (e[17:16])
				2'd0: o = {2'b00, link_alarm_o, alarm_active_o, alarm_code_o};
				2'd1: o = link_rdata_o;
				2'd2: o = {14'h0000, drive_state_o};
				default: o = {4'h0, hist_code_o};
			endcase
			`CMP(o, e[15:0])
		end
	end
	task automatic cause(input int i, input logic on);
		case (i)
			0: sel1[4] <= on ? 4'h1 : 4'h5;
			1: sel2[2] <= on ? 4'h0 : 4'h3;
			2: store_crc_fail_i <= on;
			3: pos_limit_i <= on;
			4: neg_limit_i <= on;
			default: forced_alarm_i <= on;
		endcase
		wt(1);
	endtask
	task automatic clear(input int m);
		if (m == 0) begin
			i_mst.clear_alarm();
		end else if (m == 1) begin
			panel_alarm_clear_function_i <= 1'b1;
			wt(1);
			panel_alarm_clear_function_i <= 1'b0;
		end else begin
			alarm_clear_input_i <= 1'b1;
			wt(8);
			alarm_clear_input_i <= 1'b0;
		end
		wt(1);
	endtask
	task automatic end_of_test();
		$display("Compared %0d, mismatched %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// The run needs well under a thousand cycles.
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	initial begin
		wt(5);
		resetn_i <= 1'b1;
		wt(1);
		motor_code_param_i <= 16'h0000;
		wt(6);
		chk(0, 16'h15f0);
		chk(2, 16'h0001);
		clear(0);
		wt(3);
		chk(0, 16'h15f0);
		motor_code_param_i <= {10'h000, 6'($random(seed))} + 16'h0001;
		clear(0);
		wt(3);
		chk(0, 16'h0000);
		chk(2, 16'h0003);
		i_mst.fault_reset();
		wt(2);
		chk(2, 16'h0000);
		$display("motor code test done");
		for (int i = 0; i < 6; i++) begin
			cause(i, 1'b1);
			wt(6);
			chk(0, {4'h1, codes[i]});
			cause(i, 1'b0);
			wt(6);
			chk(0, {4'h1, codes[i]});
			clear(i % 3);
			wt(6);
			chk(0, 16'h0000);
			i_mst.fault_reset();
			wt(2);
			chk(2, 16'h0000);
		end
		$display("alarm cause test done");
		lcode = 16'h0001 | 16'($random(seed));
		link_err_code_i <= lcode;
		link_err_i <= 1'b1;
		wt(1);
		link_err_i <= 1'b0;
		link_err_code_i <= ~lcode;
		wt(1);
		chk(0, 16'h2000);
		i_mst.acc(1'b1, sam_pkg::REG_LINK_STATUS, 16'h0000);
		i_mst.acc(1'b0, sam_pkg::REG_LINK_STATUS, 16'h0000);
		chk(1, lcode);
		i_mst.link_clear();
		chk(1, 16'h0000);
		wt(2);
		chk(2, 16'h0000);
		// The control register keeps the acknowledge the master wrote.
		i_mst.acc(1'b0, sam_pkg::REG_LINK_CONTROL, 16'h0000);
		chk(1, 16'h0010);
		for (int s = 0; s < 4; s++) begin
			hist_sel_i <= 2'(s);
			wt(2);
			chk(3, {4'h0, codes[s + 2]});
		end
		$display("link alarm test done");
		wt(2);
		end_of_test();
	end
endmodule
